// [daa_pkg.sv]
// Purpose: Shared constants for the debug address attribute block.
// Assumes: One system clock, synchronous active-low reset.
// Notes: Field positions follow the two attribute register layouts.
package daa_pkg;
  localparam logic [3:0] DAA_TRIG_REG_INDEX = 4'h6;
  localparam logic [7:0] DAA_ACCESS_RESET = 8'h05;
  localparam logic [15:0] DAA_TRIG_RESET = 16'h0000;
  localparam int DAA_DIR_BIT = 7;
  localparam int DAA_SIZE_LSB = 5;
  localparam int DAA_TYPE_LSB = 3;
  localparam int DAA_MOD_LSB = 0;
  localparam int DAA_ATTR_WIDTH = 8;
  localparam int DAA_MASK_LSB = 8;
  localparam int DAA_DIR_MASK_BIT = 15;
  localparam logic [1:0] DAA_SIZE_LONG = 2'h0;
  localparam logic [1:0] DAA_SIZE_BYTE = 2'h1;
  localparam logic [1:0] DAA_SIZE_WORD = 2'h2;
  localparam logic [1:0] DAA_TYPE_NORMAL = 2'h0;
  localparam logic [2:0] DAA_MOD_USER_DATA = 3'h1;
  localparam logic [2:0] DAA_MOD_USER_CODE = 3'h2;
  localparam logic [2:0] DAA_MOD_SUPV_DATA = 3'h5;
  localparam logic [2:0] DAA_MOD_SUPV_CODE = 3'h6;
endpackage : daa_pkg

// [daa_attr_compare.sv]
// Purpose: Masked compare of trigger attributes against bus attributes.
// Assumes: Bus attributes are on the same clock.
// Notes: One generate loop covers the eight attribute bits.
`timescale 1ns/100ps
`default_nettype none
module daa_attr_compare (
  input wire logic [7:0] refAttr,
  input wire logic [7:0] maskBits,
  input wire logic [7:0] busAttr,
  output logic matchAll
);
  logic [7:0] bitOk;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : gBit
      assign bitOk[i] = maskBits[i] | (refAttr[i] == busAttr[i]);
    end
  endgenerate
  assign matchAll = &bitOk;
endmodule // daa_attr_compare
`default_nettype wire

// [daa_bus_attr.sv]
// Purpose: Packs the local bus attribute signals into one byte.
// Assumes: Fields use the same layout as the trigger register.
// Notes: Read is one, write is zero.
`timescale 1ns/100ps
`default_nettype none
module daa_bus_attr (
  input wire logic busRead,
  input wire logic [1:0] busSize,
  input wire logic [1:0] busType,
  input wire logic [2:0] busModifier,
  output logic [7:0] busAttr
);
  assign busAttr = {busRead, busSize, busType, busModifier};
endmodule // daa_bus_attr
`default_nettype wire

// [daa_top.sv]
// Purpose: Debug access attribute and attribute trigger registers.
// Assumes: Debug register writes and commands arrive on this clock.
// Notes: Match output is registered, one cycle after the bus attributes.
`timescale 1ns/100ps
`default_nettype none
module daa_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic dregWrite,
  input wire logic [3:0] dregIndex,
  input wire logic [31:0] dregWdata,
  input wire logic cmdLoad,
  input wire logic cmdRead,
  input wire logic [1:0] cmdSize,
  input wire logic attrWrite,
  input wire logic [4:0] attrWdata,
  input wire logic busRead,
  input wire logic [1:0] busSize,
  input wire logic [1:0] busType,
  input wire logic [2:0] busModifier,
  input wire logic trigEnable,
  output logic [31:0] accessAttr,
  output logic [31:0] trigAttr,
  output logic memRead,
  output logic [1:0] memSize,
  output logic [1:0] memType,
  output logic [2:0] memModifier,
  output logic attrMatch
);
  logic trigWrite;
  logic wrDir;
  logic [1:0] wrSize;
  logic [1:0] wrType;
  logic [2:0] wrMod;
  logic wrDirMask;
  logic [1:0] wrSizeMask;
  logic [1:0] wrTypeMask;
  logic [2:0] wrModMask;
  logic trigDir_r;
  logic [1:0] trigSize_r;
  logic [1:0] trigType_r;
  logic [2:0] trigMod_r;
  logic trigDirMask_r;
  logic [1:0] trigSizeMask_r;
  logic [1:0] trigTypeMask_r;
  logic [2:0] trigModMask_r;
  logic [7:0] trigRef;
  logic [7:0] trigMask;
  logic accessDir_r;
  logic accessDir_nxt;
  logic [1:0] accessSize_r;
  logic [1:0] accessSize_nxt;
  logic [1:0] accessType_r;
  logic [1:0] accessType_nxt;
  logic [2:0] accessMod_r;
  logic [2:0] accessMod_nxt;
  logic [7:0] accessNext;
  logic [7:0] busAttr;
  logic matchNow;
  logic attrMatch_r;

  assign trigWrite = dregWrite && (dregIndex == daa_pkg::DAA_TRIG_REG_INDEX);

  // Field views of the written word; its upper sixteen bits are never stored.
  assign wrDir = dregWdata[daa_pkg::DAA_DIR_BIT];
  assign wrSize = dregWdata[daa_pkg::DAA_SIZE_LSB +: 2];
  assign wrType = dregWdata[daa_pkg::DAA_TYPE_LSB +: 2];
  assign wrMod = dregWdata[daa_pkg::DAA_MOD_LSB +: 3];
  assign wrDirMask = dregWdata[daa_pkg::DAA_DIR_MASK_BIT];
  assign wrSizeMask = dregWdata[daa_pkg::DAA_MASK_LSB + daa_pkg::DAA_SIZE_LSB +: 2];
  assign wrTypeMask = dregWdata[daa_pkg::DAA_MASK_LSB + daa_pkg::DAA_TYPE_LSB +: 2];
  assign wrModMask = dregWdata[daa_pkg::DAA_MASK_LSB + daa_pkg::DAA_MOD_LSB +: 3];

  // Trigger register, kept as one flop group per field.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      trigDir_r <= daa_pkg::DAA_TRIG_RESET[daa_pkg::DAA_DIR_BIT];
    end else if (trigWrite) begin
      trigDir_r <= wrDir;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trigSize_r <= daa_pkg::DAA_TRIG_RESET[daa_pkg::DAA_SIZE_LSB +: 2];
    end else if (trigWrite) begin
      trigSize_r <= wrSize;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trigType_r <= daa_pkg::DAA_TRIG_RESET[daa_pkg::DAA_TYPE_LSB +: 2];
    end else if (trigWrite) begin
      trigType_r <= wrType;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trigMod_r <= daa_pkg::DAA_TRIG_RESET[daa_pkg::DAA_MOD_LSB +: 3];
    end else if (trigWrite) begin
      trigMod_r <= wrMod;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trigDirMask_r <= daa_pkg::DAA_TRIG_RESET[daa_pkg::DAA_DIR_MASK_BIT];
    end else if (trigWrite) begin
      trigDirMask_r <= wrDirMask;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trigSizeMask_r <= daa_pkg::DAA_TRIG_RESET[daa_pkg::DAA_MASK_LSB + daa_pkg::DAA_SIZE_LSB +: 2];
    end else if (trigWrite) begin
      trigSizeMask_r <= wrSizeMask;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trigTypeMask_r <= daa_pkg::DAA_TRIG_RESET[daa_pkg::DAA_MASK_LSB + daa_pkg::DAA_TYPE_LSB +: 2];
    end else if (trigWrite) begin
      trigTypeMask_r <= wrTypeMask;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trigModMask_r <= daa_pkg::DAA_TRIG_RESET[daa_pkg::DAA_MASK_LSB + daa_pkg::DAA_MOD_LSB +: 3];
    end else if (trigWrite) begin
      trigModMask_r <= wrModMask;
    end
  end

  assign trigRef = {trigDir_r, trigSize_r, trigType_r, trigMod_r};
  assign trigMask = {trigDirMask_r, trigSizeMask_r, trigTypeMask_r, trigModMask_r};

  // Access register fields; a trigger register write outranks host and command loads.
  always_comb begin
    accessDir_nxt = accessDir_r;
    if (trigWrite) begin
      accessDir_nxt = wrDir;
    end else if (cmdLoad) begin
      accessDir_nxt = cmdRead;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      accessDir_r <= daa_pkg::DAA_ACCESS_RESET[daa_pkg::DAA_DIR_BIT];
    end else begin
      accessDir_r <= accessDir_nxt;
    end
  end

  always_comb begin
    accessSize_nxt = accessSize_r;
    if (trigWrite) begin
      accessSize_nxt = wrSize;
    end else if (cmdLoad) begin
      accessSize_nxt = cmdSize;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      accessSize_r <= daa_pkg::DAA_ACCESS_RESET[daa_pkg::DAA_SIZE_LSB +: 2];
    end else begin
      accessSize_r <= accessSize_nxt;
    end
  end

  always_comb begin
    accessType_nxt = accessType_r;
    if (trigWrite) begin
      accessType_nxt = wrType;
    end else if (attrWrite) begin
      accessType_nxt = attrWdata[daa_pkg::DAA_TYPE_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      accessType_r <= daa_pkg::DAA_ACCESS_RESET[daa_pkg::DAA_TYPE_LSB +: 2];
    end else begin
      accessType_r <= accessType_nxt;
    end
  end

  always_comb begin
    accessMod_nxt = accessMod_r;
    if (trigWrite) begin
      accessMod_nxt = wrMod;
    end else if (attrWrite) begin
      accessMod_nxt = attrWdata[daa_pkg::DAA_MOD_LSB +: 3];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      accessMod_r <= daa_pkg::DAA_ACCESS_RESET[daa_pkg::DAA_MOD_LSB +: 3];
    end else begin
      accessMod_r <= accessMod_nxt;
    end
  end

  // Only eight bits are kept, so writes to the reserved upper part are lost.
  assign accessNext = {accessDir_nxt, accessSize_nxt, accessType_nxt, accessMod_nxt};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      accessAttr <= {24'h000000, daa_pkg::DAA_ACCESS_RESET};
    end else begin
      accessAttr <= {24'h000000, accessNext};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      trigAttr <= {16'h0000, daa_pkg::DAA_TRIG_RESET};
    end else if (trigWrite) begin
      trigAttr <= {16'h0000, wrDirMask, wrSizeMask, wrTypeMask, wrModMask,
        wrDir, wrSize, wrType, wrMod};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      memRead <= daa_pkg::DAA_ACCESS_RESET[daa_pkg::DAA_DIR_BIT];
    end else begin
      memRead <= accessDir_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      memSize <= daa_pkg::DAA_ACCESS_RESET[daa_pkg::DAA_SIZE_LSB +: 2];
    end else begin
      memSize <= accessSize_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      memType <= daa_pkg::DAA_ACCESS_RESET[daa_pkg::DAA_TYPE_LSB +: 2];
    end else begin
      memType <= accessType_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      memModifier <= daa_pkg::DAA_ACCESS_RESET[daa_pkg::DAA_MOD_LSB +: 3];
    end else begin
      memModifier <= accessMod_nxt;
    end
  end

  daa_bus_attr daa_bus_attr_i (
    .busRead(busRead),
    .busSize(busSize),
    .busType(busType),
    .busModifier(busModifier),
    .busAttr(busAttr)
  );

  daa_attr_compare daa_attr_compare_i (
    .refAttr(trigRef),
    .maskBits(trigMask),
    .busAttr(busAttr),
    .matchAll(matchNow)
  );

  // Registered so that the match output comes straight from a flop.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      attrMatch_r <= 1'b0;
    end else begin
      attrMatch_r <= trigEnable && matchNow;
    end
  end

  assign attrMatch = attrMatch_r;
endmodule // daa_top
`default_nettype wire

// [daa_host.sv]
// Purpose: Host model for debug writes.
// Assumes: Drives at falling edge.
// Notes: One-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module daa_host (
  input wire logic clk,
  output logic dregWrite,
  output logic cmdLoad,
  output logic cmdRead,
  output logic attrWrite,
  output logic [3:0] dregIndex,
  output logic [31:0] dregWdata,
  output logic [1:0] cmdSize,
  output logic [4:0] attrWdata
);
  initial {dregWrite, cmdLoad, attrWrite, dregIndex, dregWdata, cmdRead, cmdSize, attrWdata} = '0;
  task automatic req(input logic [2:0] k, input logic [3:0] x, input logic [31:0] d);
    @(negedge clk);
    {attrWrite, cmdLoad, dregWrite} = k;
    dregIndex = x;
    dregWdata = d;
    {cmdRead, cmdSize, attrWdata} = d[7:0];
    @(negedge clk);
    {attrWrite, cmdLoad, dregWrite} = 3'h0;
    dregWdata = ~d;
  endtask
endmodule // daa_host
`default_nettype wire

// [daa_asserts.sv]
// Purpose: Port checks.
// Assumes: One clock.
// Notes: Bound to top.
`timescale 1ns/100ps
`default_nettype none
module daa_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic dregWrite,
  input wire logic cmdLoad,
  input wire logic cmdRead,
  input wire logic attrWrite,
  input wire logic busRead,
  input wire logic trigEnable,
  input wire logic memRead,
  input wire logic attrMatch,
  input wire logic [3:0] dregIndex,
  input wire logic [31:0] dregWdata,
  input wire logic [31:0] accessAttr,
  input wire logic [31:0] trigAttr,
  input wire logic [1:0] cmdSize,
  input wire logic [1:0] busSize,
  input wire logic [1:0] busType,
  input wire logic [1:0] memSize,
  input wire logic [1:0] memType,
  input wire logic [4:0] attrWdata,
  input wire logic [2:0] busModifier,
  input wire logic [2:0] memModifier
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic tw = dregWrite && dregIndex == 4'h6;
  sequence s_tw; tw; endsequence
  property p_rst; disable iff (1'b0) !nrst |=> accessAttr == 32'h5; endproperty
  a_rst: assert property (p_rst) else $error("a_rst");
  property p_up; accessAttr[31:8] == 24'h0; endproperty
  a_up: assert property (p_up) else $error("a_up");
  property p_tw; s_tw |=> accessAttr[7:0] == $past(dregWdata[7:0]); endproperty
  a_tw: assert property (p_tw) else $error("a_tw");
  property p_tr; s_tw |=> trigAttr == {16'h0, $past(dregWdata[15:0])}; endproperty
  a_tr: assert property (p_tr) else $error("a_tr");
  property p_cmd; cmdLoad && !tw |=> accessAttr[7:5] == $past({cmdRead, cmdSize}); endproperty
  a_cmd: assert property (p_cmd) else $error("a_cmd");
  property p_hw; attrWrite && !tw |=> accessAttr[4:0] == $past(attrWdata); endproperty
  a_hw: assert property (p_hw) else $error("a_hw");
  property p_mem; {memRead, memSize, memType, memModifier} == accessAttr[7:0]; endproperty
  a_mem: assert property (p_mem) else $error("a_mem");
  property p_mt; $past(nrst) |-> attrMatch == $past(trigEnable &&
    ((({busRead, busSize, busType, busModifier} ^ trigAttr[7:0]) & ~trigAttr[15:8]) == 8'h0));
  endproperty
  a_mt: assert property (p_mt) else $error("a_mt");
endmodule // daa_asserts
bind daa_top daa_asserts daa_asserts_i (
  .clk(clk),
  .nrst(nrst),
  .dregWrite(dregWrite),
  .cmdLoad(cmdLoad),
  .cmdRead(cmdRead),
  .attrWrite(attrWrite),
  .busRead(busRead),
  .trigEnable(trigEnable),
  .memRead(memRead),
  .attrMatch(attrMatch),
  .dregIndex(dregIndex),
  .dregWdata(dregWdata),
  .accessAttr(accessAttr),
  .trigAttr(trigAttr),
  .cmdSize(cmdSize),
  .busSize(busSize),
  .busType(busType),
  .memSize(memSize),
  .memType(memType),
  .attrWdata(attrWdata),
  .busModifier(busModifier),
  .memModifier(memModifier)
);
`default_nettype wire

// [daa_top_bench.sv]
// Purpose: Bench.
// Assumes: Falling-edge drive.
// Notes: Host model.
`timescale 1ns/100ps
`default_nettype none
module daa_top_bench;
  logic clk = 0, nrst = 0, busRead = 0, trigEnable = 1;
  logic [1:0] busSize = 0, busType = 0;
  logic [2:0] busModifier = 0;
  wire logic dregWrite, cmdLoad, cmdRead, attrWrite, memRead, attrMatch;
  wire logic [3:0] dregIndex;
  wire logic [31:0] dregWdata, accessAttr, trigAttr;
  wire logic [1:0] cmdSize, memSize, memType;
  wire logic [4:0] attrWdata;
  wire logic [2:0] memModifier;
  int n_fail = 0, checked = 0, cyc = 0;
  daa_host daa_host_i (
    .clk(clk),
    .dregWrite(dregWrite),
    .cmdLoad(cmdLoad),
    .cmdRead(cmdRead),
    .attrWrite(attrWrite),
    .dregIndex(dregIndex),
    .dregWdata(dregWdata),
    .cmdSize(cmdSize),
    .attrWdata(attrWdata)
  );
  daa_top daa_top_i (
    .clk(clk),
    .nrst(nrst),
    .dregWrite(dregWrite),
    .dregIndex(dregIndex),
    .dregWdata(dregWdata),
    .cmdLoad(cmdLoad),
    .cmdRead(cmdRead),
    .cmdSize(cmdSize),
    .attrWrite(attrWrite),
    .attrWdata(attrWdata),
    .busRead(busRead),
    .busSize(busSize),
    .busType(busType),
    .busModifier(busModifier),
    .trigEnable(trigEnable),
    .accessAttr(accessAttr),
    .trigAttr(trigAttr),
    .memRead(memRead),
    .memSize(memSize),
    .memType(memType),
    .memModifier(memModifier),
    .attrMatch(attrMatch)
  );
  initial forever #20 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test();
    $display("fails %0d checks %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 1000) begin
    n_fail++;
    finish_test();
  end
  task automatic t_regs();
    chk("acc", accessAttr, 32'h5);
    chk("mem", {memRead, memSize, memType, memModifier}, 32'h5);
    daa_host_i.req(3'h1, 4'h6, 32'hFFFF8305);
    chk("trig", trigAttr, 32'h8305);
    chk("acc", accessAttr, 32'h5);
    daa_host_i.req(3'h3, 4'h7, 32'hC0);
    chk("trig", trigAttr, 32'h8305);
    chk("acc", accessAttr, 32'hC5);
    daa_host_i.req(3'h4, 4'h0, 32'hFFFFFFF6);
    chk("acc", accessAttr, 32'hD6);
    daa_host_i.req(3'h6, 4'h0, 32'h2E);
    chk("mem", {memRead, memSize, memType, memModifier}, 32'h2E);
    daa_host_i.req(3'h7, 4'h6, 32'hA9);
    chk("acc", accessAttr, 32'hA9);
  endtask
  task automatic t_match();
    for (int i = 0; i < 18; i++) begin
      trigEnable = (i != 16);
      daa_host_i.req(3'h1, 4'h6, {16'h0, i < 8 ? 8'h1 << i : 8'h0, 8'hA5});
      {busRead, busSize, busType, busModifier} = 8'hA5 ^ (i < 16 ? 8'h1 << (i % 8) : 8'h0);
      @(negedge clk);
      chk("match", attrMatch, i < 8 || i == 17);
    end
  endtask
  task automatic t_reset();
    @(negedge clk);
    nrst = 0;
    repeat (2) @(negedge clk);
    nrst = 1;
    chk("acc", accessAttr, 32'h5);
    chk("trig", trigAttr, 32'h0);
    chk("match", attrMatch, 1'b0);
    daa_host_i.req(3'h2, 4'h0, 32'h20);
    chk("acc", accessAttr, 32'h25);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1;
    t_regs();
    t_match();
    t_reset();
    finish_test();
  end
endmodule // daa_top_bench
`default_nettype wire
